// ==== include/lhbms_consts.vh ====
`ifndef LHBMS_CONSTS_VH
`define LHBMS_CONSTS_VH

// Bus mode strap codes
`define LHBMS_BM_P68_16    2'h3
`define LHBMS_BM_P80_16    2'h2
`define LHBMS_BM_P68_8     2'h1
`define LHBMS_BM_P80_8     2'h0
// High lane strap values for serial selection
`define LHBMS_HL_SER       2'h2
`define LHBMS_HL_SER_C     2'h3
`define LHBMS_HL_BIT_HI    15
`define LHBMS_HL_BIT_LO    13

// Decoded modes
`define LHBMS_MODE_W       3
`define LHBMS_M_P68_16     3'h0
`define LHBMS_M_P80_16     3'h1
`define LHBMS_M_P68_8      3'h2
`define LHBMS_M_P80_8      3'h3
`define LHBMS_M_SER8       3'h4
`define LHBMS_M_SERC       3'h5
`define LHBMS_M_SER9       3'h6
`define LHBMS_M_NONE       3'h7

// Serial pins
`define LHBMS_SCK_BIT      0
`define LHBMS_SDA_BIT      8
`define LHBMS_TOK8_LAST    4'h7
`define LHBMS_TOK9_LAST    4'h8

// Data path
`define LHBMS_DW           16
`define LHBMS_FIFO_W       17
`define LHBMS_FIFO_DEPTH   8
`define LHBMS_FIFO_AW      3
`define LHBMS_BYTE0        8'h00
`define LHBMS_WORD0        16'h0000

`endif

// ==== core/lhbms_fifo.v ====
`timescale 1ns/1ps
module lhbms_fifo #(
	parameter WIDTH = 17,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	input  wire             ce,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            do_push;
	wire            do_pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	always @(posedge clk) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (do_push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (do_push & ~do_pop)
				count <= count + 1'b1;
			else if (do_pop & ~do_push)
				count <= count - 1'b1;
		end
	end
endmodule

// ==== core/lhbms_port.v ====
`timescale 1ns/1ps
`include "lhbms_consts.vh"
module lhbms_port (
	// Clock, reset, enable
	input  wire                      clk,
	input  wire                      rst,
	input  wire                      ce,
	// Straps
	input  wire [1:0]                bus_mode_strap,
	input  wire                      lane_select_strap,
	input  wire                      lane_aux_strap,
	input  wire                      factory_test_pin,
	// Host pins
	input  wire                      cs_n,
	input  wire                      cmd_data_sel,
	input  wire                      strobe_pin_a,
	input  wire                      strobe_pin_b,
	input  wire [15:0]               host_data_in,
	output reg  [15:0]               host_data_out,
	output wire [15:0]               host_data_oe,
	// Status
	output reg  [`LHBMS_MODE_W-1:0]  bus_mode,
	output reg  [1:0]                strap_readback_field,
	output wire                      test_pin_low,
	output wire                      host_busy,
	output reg                       overrun,
	// Internal write stream
	output wire                      wr_valid,
	input  wire                      wr_ready,
	output wire [15:0]               wr_word,
	output wire                      wr_is_data,
	// Internal read source
	output reg                       rd_req,
	input  wire [15:0]               rd_word
);
	reg        lane_hi;
	reg        strb_a_q;
	reg        strb_b_q;
	reg        sck_q;
	reg        byte_phase;
	reg [7:0]  low_byte;
	reg [8:0]  shreg;
	reg [3:0]  bit_cnt;
	reg [15:0] rd_hold;
	reg        pend_valid;
	reg [16:0] pend_data;
	reg        next_pend_valid;
	reg [16:0] next_pend_data;
	reg        next_byte_phase;
	reg [7:0]  next_low_byte;
	reg        got_byte;
	reg        got_cd;
	reg [7:0]  got_val;
	reg        got_word;
	reg [15:0] got_wval;
	wire       fifo_in_ready;
	wire [16:0] fifo_out;
	// A full stage keeps its word; the newcomer is the one dropped
	wire        stage_full = pend_valid & ~fifo_in_ready;

	// Lane mapping used on both write capture and read drive
	function [7:0] lane_pick;
		input [15:0] pins;
		input        hi;
		integer      i;
		begin
			for (i = 0; i < 8; i = i + 1)
				lane_pick[i] = hi ? pins[i] : pins[2*i];
		end
	endfunction

	function [15:0] lane_put;
		input [7:0] b;
		input       hi;
		integer     i;
		begin
			lane_put = `LHBMS_WORD0;
			for (i = 0; i < 8; i = i + 1) begin
				if (hi)
					lane_put[i] = b[i];
				else
					lane_put[2*i] = b[i];
			end
		end
	endfunction

	wire is_p68  = (bus_mode == `LHBMS_M_P68_16) | (bus_mode == `LHBMS_M_P68_8);
	wire is_p80  = (bus_mode == `LHBMS_M_P80_16) | (bus_mode == `LHBMS_M_P80_8);
	wire is_8bit = (bus_mode == `LHBMS_M_P68_8) | (bus_mode == `LHBMS_M_P80_8);
	wire is_ser  = (bus_mode == `LHBMS_M_SER8) | (bus_mode == `LHBMS_M_SERC) | (bus_mode == `LHBMS_M_SER9);
	wire sel     = ~cs_n;

	// 6800: a is read/write (high reads), b is the enable; 8080: a writes, b reads, both low active
	wire rd_act  = sel & (is_p68 ? (strobe_pin_b & strobe_pin_a) : (is_p80 & ~strobe_pin_b));
	wire rd_prev = is_p68 ? (strb_b_q & strb_a_q) : (is_p80 & ~strb_b_q);
	wire rd_start = rd_act & ~rd_prev;
	wire wr_done = sel & (is_p68 ? (strb_b_q & ~strobe_pin_b & ~strobe_pin_a)
		: (is_p80 & ~strb_a_q & strobe_pin_a));

	wire sck_rise = sel & is_ser & host_data_in[`LHBMS_SCK_BIT] & ~sck_q;
	wire [3:0] tok_last = (bus_mode == `LHBMS_M_SER9) ? `LHBMS_TOK9_LAST : `LHBMS_TOK8_LAST;

	// Drive the pins only during a selected parallel read
	assign host_data_oe = rd_act ? (is_8bit ? lane_put(8'hFF, lane_hi) : 16'hFFFF) : `LHBMS_WORD0;
	assign test_pin_low = ~factory_test_pin;
	assign host_busy    = pend_valid;

	// Strap capture while reset is held; frozen afterwards
	always @(posedge clk) begin
		if (rst) begin
			lane_hi              <= lane_select_strap;
			strap_readback_field <= {lane_select_strap, lane_aux_strap};
			case (bus_mode_strap)
			`LHBMS_BM_P68_16: bus_mode <= `LHBMS_M_P68_16;
			`LHBMS_BM_P80_16: bus_mode <= `LHBMS_M_P80_16;
			`LHBMS_BM_P68_8: begin
				if ({host_data_in[`LHBMS_HL_BIT_HI], host_data_in[`LHBMS_HL_BIT_LO]} == `LHBMS_HL_SER)
					bus_mode <= `LHBMS_M_SER9;
				else if (~host_data_in[`LHBMS_HL_BIT_HI])
					bus_mode <= `LHBMS_M_P68_8;
				else
					bus_mode <= `LHBMS_M_NONE;
			end
			`LHBMS_BM_P80_8: begin
				if ({host_data_in[`LHBMS_HL_BIT_HI], host_data_in[`LHBMS_HL_BIT_LO]} == `LHBMS_HL_SER)
					bus_mode <= `LHBMS_M_SER8;
				else if ({host_data_in[`LHBMS_HL_BIT_HI], host_data_in[`LHBMS_HL_BIT_LO]} == `LHBMS_HL_SER_C)
					bus_mode <= `LHBMS_M_SERC;
				else
					bus_mode <= `LHBMS_M_P80_8;
			end
			default: bus_mode <= `LHBMS_M_NONE;
			endcase
		end
	end

	// Byte or word arrival from whichever port is live
	always @* begin
		got_byte = 1'b0;
		got_word = 1'b0;
		got_cd   = cmd_data_sel;
		got_val  = `LHBMS_BYTE0;
		got_wval = `LHBMS_WORD0;
		if (wr_done) begin
			if (is_8bit) begin
				got_byte = 1'b1;
				got_val  = lane_pick(host_data_in, lane_hi);
			end else begin
				got_word = 1'b1;
				got_wval = host_data_in;
			end
		end else if (sck_rise && bit_cnt == tok_last) begin
			got_byte = 1'b1;
			if (bus_mode == `LHBMS_M_SER9) begin
				got_cd  = shreg[7];
				got_val = {shreg[6:0], host_data_in[`LHBMS_SDA_BIT]};
			end else begin
				got_val = {shreg[6:0], host_data_in[`LHBMS_SDA_BIT]};
			end
		end
	end

	// Pairing: data bytes pair low then high; a command byte stands alone
	always @* begin
		next_pend_valid = pend_valid;
		next_pend_data  = pend_data;
		next_byte_phase = byte_phase;
		next_low_byte   = low_byte;
		if (pend_valid & fifo_in_ready)
			next_pend_valid = 1'b0;
		if (got_word) begin
			if (!stage_full) begin
				next_pend_valid = 1'b1;
				next_pend_data  = {got_cd, got_wval};
			end
		end else if (got_byte) begin
			if (!got_cd) begin
				if (!stage_full) begin
					next_pend_valid = 1'b1;
					next_pend_data  = {got_cd, `LHBMS_BYTE0, got_val};
				end
				next_byte_phase = 1'b0;
			end else if (!byte_phase) begin
				next_low_byte   = got_val;
				next_byte_phase = 1'b1;
			end else begin
				if (!stage_full) begin
					next_pend_valid = 1'b1;
					next_pend_data  = {got_cd, got_val, low_byte};
				end
				next_byte_phase = 1'b0;
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			strb_a_q      <= 1'b1;
			strb_b_q      <= 1'b1;
			sck_q         <= 1'b0;
			byte_phase    <= 1'b0;
			low_byte      <= `LHBMS_BYTE0;
			shreg         <= 9'h000;
			bit_cnt       <= 4'h0;
			pend_valid    <= 1'b0;
			pend_data     <= 17'h00000;
			overrun       <= 1'b0;
			rd_req        <= 1'b0;
			rd_hold       <= `LHBMS_WORD0;
			host_data_out <= `LHBMS_WORD0;
		end else if (ce) begin
			strb_a_q   <= strobe_pin_a;
			strb_b_q   <= strobe_pin_b;
			sck_q      <= host_data_in[`LHBMS_SCK_BIT];
			pend_valid <= next_pend_valid;
			pend_data  <= next_pend_data;
			byte_phase <= next_byte_phase;
			low_byte   <= next_low_byte;
			// A word arriving while the stage is still full is lost
			if (pend_valid & ~fifo_in_ready & (got_word | (got_byte & (~got_cd | byte_phase))))
				overrun <= 1'b1;
			// Serial token framing restarts whenever the chip is deselected
			if (cs_n) begin
				bit_cnt <= 4'h0;
			end else if (sck_rise) begin
				shreg   <= {shreg[7:0], host_data_in[`LHBMS_SDA_BIT]};
				bit_cnt <= (bit_cnt == tok_last) ? 4'h0 : bit_cnt + 4'h1;
			end
			// Read: fetch a word on first byte, present high byte on the second
			rd_req <= rd_start & (~is_8bit | ~byte_phase);
			if (rd_start) begin
				if (!is_8bit) begin
					host_data_out <= rd_word;
				end else if (!byte_phase) begin
					rd_hold       <= rd_word;
					host_data_out <= lane_put(rd_word[7:0], lane_hi);
					byte_phase    <= 1'b1;
				end else begin
					host_data_out <= lane_put(rd_hold[15:8], lane_hi);
					byte_phase    <= 1'b0;
				end
			end
		end
	end

	// Eight-word buffer; any word waiting in the stage raises host_busy back to the host
	lhbms_fifo #(
		.WIDTH (`LHBMS_FIFO_W),
		.DEPTH (`LHBMS_FIFO_DEPTH),
		.AW    (`LHBMS_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.in_valid  (pend_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (pend_data),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (fifo_out)
	);

	assign wr_word    = fifo_out[15:0];
	assign wr_is_data = fifo_out[16];
endmodule

// ==== sim/lhbms_port_props.sv ====
`timescale 1ns/1ps
`include "lhbms_consts.vh"
module lhbms_port_props (
	// Clock and reset
	input wire                     clk,
	input wire                     rst,
	// Straps and host pins
	input wire                     lane_select_strap,
	input wire                     lane_aux_strap,
	input wire                     cs_n,
	input wire                     strobe_pin_a,
	input wire                     strobe_pin_b,
	input wire [15:0]              host_data_out,
	input wire [15:0]              host_data_oe,
	// Status and streams
	input wire [`LHBMS_MODE_W-1:0] bus_mode,
	input wire [1:0]               strap_readback_field,
	input wire                     host_busy,
	input wire                     wr_valid,
	input wire                     wr_ready,
	input wire [15:0]              wr_word,
	input wire                     wr_is_data,
	input wire                     rd_req,
	input wire [15:0]              rd_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire p80 = bus_mode == `LHBMS_M_P80_16;
	wire p68 = bus_mode == `LHBMS_M_P68_16;

	mode_hold_a: assert property (!$past(rst) |-> $stable(bus_mode) && $stable(strap_readback_field))
		else $error("mode moved outside reset");
	strap_cap_a: assert property (disable iff (1'b0)
		rst |=> strap_readback_field == $past({lane_select_strap, lane_aux_strap}))
		else $error("readback wrong");
	idle_oe_a: assert property (cs_n |-> host_data_oe == 16'h0000)
		else $error("drive while idle");
	read_oe_a: assert property (p80 && !cs_n && !strobe_pin_b |-> host_data_oe == 16'hFFFF)
		else $error("no drive in read");
	read_data_a: assert property (!cs_n && (p80 && $fell(strobe_pin_b) ||
		p68 && strobe_pin_a && $rose(strobe_pin_b)) |=> rd_req && host_data_out == $past(rd_word))
		else $error("read data wrong");
	read_pulse_a: assert property (rd_req |=> !rd_req)
		else $error("long read pulse");
	write_take_a: assert property (!cs_n && !host_busy && (p80 && $rose(strobe_pin_a) ||
		p68 && !strobe_pin_a && $fell(strobe_pin_b)) |=> host_busy)
		else $error("write not taken");
	word_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_is_data, wr_word}))
		else $error("word dropped");
endmodule

bind lhbms_port lhbms_port_props i_lhbms_port_props (.clk(clk), .rst(rst), .lane_select_strap(lane_select_strap),
	.lane_aux_strap(lane_aux_strap), .cs_n(cs_n), .strobe_pin_a(strobe_pin_a), .strobe_pin_b(strobe_pin_b),
	.host_data_out(host_data_out), .host_data_oe(host_data_oe), .bus_mode(bus_mode),
	.strap_readback_field(strap_readback_field), .host_busy(host_busy), .wr_valid(wr_valid),
	.wr_ready(wr_ready), .wr_word(wr_word), .wr_is_data(wr_is_data), .rd_req(rd_req), .rd_word(rd_word));

// ==== sim/lhbms_host.sv ====
`timescale 1ns/1ps
module lhbms_host (
	// Clock
	input wire         clk,
	// Host pins
	output reg         cs_n,
	output reg         cmd_data_sel,
	output reg         strobe_pin_a,
	output reg         strobe_pin_b,
	output wire [15:0] pins,
	// Device drive
	input wire [15:0]  host_data_out,
	input wire [15:0]  host_data_oe
);
	reg        m68 = 1'b0;
	reg [15:0] hdrv = 16'h0000;
	initial {cs_n, cmd_data_sel, strobe_pin_a, strobe_pin_b} = 4'hB;
	// Device wins on every pin it enables
	assign pins = (host_data_oe & host_data_out) | (~host_data_oe & hdrv);

	task xfer(input rd, input cd, input [15:0] d, output [15:0] q);
		begin
			@(posedge clk);
			cs_n <= 1'b0;
			cmd_data_sel <= cd;
			hdrv <= d;
			strobe_pin_a <= rd;
			strobe_pin_b <= m68 | !rd;
			repeat (2) @(posedge clk);
			#1 q = pins;
			@(posedge clk);
			strobe_pin_a <= m68 ? rd : 1'b1;
			strobe_pin_b <= !m68;
			repeat (2) @(posedge clk);
			cs_n <= 1'b1;
			// Released pins must not keep the old level
			hdrv <= ~hdrv;
			strobe_pin_a <= !m68;
		end
	endtask

	task ser(input nine, input cd, input [7:0] d);
		reg [8:0] s;
		integer   i;
		begin
			s = nine ? {cd, d} : {d, 1'b0};
			@(posedge clk);
			cs_n <= 1'b0;
			cmd_data_sel <= cd;
			for (i = 0; i < 8 + nine; i = i + 1) begin
				@(posedge clk);
				hdrv[0] <= 1'b0;
				hdrv[8] <= s[8 - i];
				repeat (2) @(posedge clk);
				hdrv[0] <= 1'b1;
				@(posedge clk);
			end
			repeat (2) @(posedge clk);
			cs_n <= 1'b1;
			// Clock parks low between frames
			hdrv[0] <= 1'b0;
			hdrv[8] <= ~hdrv[8];
		end
	endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "lhbms_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
	$display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         ce = 1'b1;
	reg  [1:0]  bm = 2'h0;
	reg         lane = 1'b0;
	reg         aux = 1'b0;
	reg         tpin = 1'b1;
	reg         wr_ready = 1'b1;
	reg  [15:0] rd_word = 16'h0000;
	reg  [15:0] q;
	reg  [16:0] expq[$];
	reg  [16:0] expw;
	integer     err_total = 0;
	integer     samples_checked = 0;
	integer     k;
	wire        cs_n, cd, sa, sb, tlow, busy, ovr, wv, wcd;
	wire [15:0] pins, dout, oe, ww;
	wire [2:0]  mode;
	wire [1:0]  rb;
	always #4 clk = ~clk;

	lhbms_host i_lhbms_host (.clk(clk), .cs_n(cs_n), .cmd_data_sel(cd), .strobe_pin_a(sa), .strobe_pin_b(sb),
		.pins(pins), .host_data_out(dout), .host_data_oe(oe));
	lhbms_port i_lhbms_port (.clk(clk), .rst(rst), .ce(ce), .bus_mode_strap(bm), .lane_select_strap(lane),
		.lane_aux_strap(aux), .factory_test_pin(tpin), .cs_n(cs_n), .cmd_data_sel(cd), .strobe_pin_a(sa),
		.strobe_pin_b(sb), .host_data_in(pins), .host_data_out(dout), .host_data_oe(oe), .bus_mode(mode),
		.strap_readback_field(rb), .test_pin_low(tlow), .host_busy(busy), .overrun(ovr), .wr_valid(wv),
		.wr_ready(wr_ready), .wr_word(ww), .wr_is_data(wcd), .rd_req(), .rd_word(rd_word));

	// Pop once into a temporary so a mismatch report cannot pop again
	always @(posedge clk)
		if (wv === 1'b1 && wr_ready) begin
			expw = expq.size() ? expq.pop_front() : 17'h1FFFF;
			`CHK({wcd, ww}, expw)
		end

	task complete_run;
		begin
			if (err_total == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	function [2:0] exp_mode(input [3:0] s);
		case (s[3:2])
			2'h3: exp_mode = `LHBMS_M_P68_16;
			2'h2: exp_mode = `LHBMS_M_P80_16;
			2'h1: exp_mode = s[1:0] == 2'h2 ? `LHBMS_M_SER9 : (s[1] ? `LHBMS_M_NONE : `LHBMS_M_P68_8);
			default: exp_mode = s[1:0] == 2'h2 ? `LHBMS_M_SER8 : (s[1] ? `LHBMS_M_SERC : `LHBMS_M_P80_8);
		endcase
	endfunction

	// Idle cycles first so the last word leaves before reset
	task reset_to(input [1:0] m, input [1:0] hl, input l, input x);
		begin
			if (!rst)
				repeat (4) @(posedge clk);
			rst <= 1'b1;
			bm <= m;
			lane <= l;
			aux <= x;
			i_lhbms_host.m68 <= m[0];
			i_lhbms_host.hdrv <= {hl[1], 1'b0, hl[0], 13'h0000};
			i_lhbms_host.strobe_pin_a <= !m[0];
			i_lhbms_host.strobe_pin_b <= !m[0];
			repeat (12) @(posedge clk);
			rst <= 1'b0;
			#1;
		end
	endtask

	// Odd pins carry ones so a wrong lane shows
	task b8(input c, input [7:0] v);
		integer    i;
		reg [15:0] s;
		begin
			s = 16'hAAAA;
			for (i = 0; i < 8; i = i + 1)
				s[2 * i] = v[i];
			i_lhbms_host.xfer(1'b0, c, s, q);
		end
	endtask

	initial begin
		for (k = 0; k < 16; k = k + 1) begin
			reset_to(k[3:2], k[1:0], k[0], k[1]);
			`CHK(mode, exp_mode(k[3:0]))
			`CHK(rb, {k[0], k[1]})
		end
		reset_to(2'h2, 2'h0, 1'b0, 1'b0);
		expq.push_back({1'b1, 16'hA5C3});
		expq.push_back(17'h000E2);
		i_lhbms_host.xfer(1'b0, 1'b1, 16'hA5C3, q);
		i_lhbms_host.xfer(1'b0, 1'b0, 16'h00E2, q);
		rd_word <= 16'h5A3C;
		i_lhbms_host.xfer(1'b1, 1'b1, 16'h0000, q);
		`CHK(q, 16'h5A3C)
		reset_to(2'h3, 2'h0, 1'b1, 1'b0);
		rd_word <= 16'hC0DE;
		i_lhbms_host.xfer(1'b1, 1'b1, 16'h0000, q);
		`CHK(q, 16'hC0DE)
		wr_ready <= 1'b0;
		for (k = 0; k < 10; k = k + 1) begin
			if (k < 9)
				expq.push_back({1'b1, 16'h0100 + k[15:0]});
			i_lhbms_host.xfer(1'b0, 1'b1, 16'h0100 + k[15:0], q);
		end
		#1 `CHK({ovr, busy, wv}, 3'h7)
		wr_ready <= 1'b1;
		repeat (20) @(posedge clk);
		#1 `CHK({busy, wv}, 2'h0)
		reset_to(2'h0, 2'h0, 1'b0, 1'b0);
		expq.push_back(17'h00081);
		expq.push_back({1'b1, 16'h3322});
		b8(1'b1, 8'h11);
		b8(1'b0, 8'h81);
		b8(1'b1, 8'h22);
		b8(1'b1, 8'h33);
		reset_to(2'h0, 2'h0, 1'b1, 1'b0);
		expq.push_back({1'b1, 16'h5544});
		i_lhbms_host.xfer(1'b0, 1'b1, 16'hA544, q);
		i_lhbms_host.xfer(1'b0, 1'b1, 16'hA555, q);
		rd_word <= 16'hBE71;
		i_lhbms_host.xfer(1'b1, 1'b1, 16'h0000, q);
		`CHK(q, 16'h0071)
		rd_word <= 16'h0000;
		i_lhbms_host.xfer(1'b1, 1'b1, 16'h0000, q);
		`CHK(q, 16'h00BE)
		reset_to(2'h0, 2'h3, 1'b0, 1'b0);
		expq.push_back(17'h0005C);
		i_lhbms_host.ser(1'b0, 1'b0, 8'h5C);
		reset_to(2'h0, 2'h2, 1'b1, 1'b0);
		expq.push_back({1'b1, 16'h6996});
		expq.push_back(17'h000E2);
		i_lhbms_host.ser(1'b0, 1'b1, 8'h96);
		i_lhbms_host.ser(1'b0, 1'b1, 8'h69);
		i_lhbms_host.ser(1'b0, 1'b0, 8'hE2);
		reset_to(2'h1, 2'h2, 1'b1, 1'b0);
		expq.push_back({1'b1, 16'hC35A});
		i_lhbms_host.ser(1'b1, 1'b1, 8'h5A);
		i_lhbms_host.ser(1'b1, 1'b1, 8'hC3);
		`CHK(tlow, 1'b0)
		tpin <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(tlow, 1'b1)
		`CHK(expq.size(), 0)
		complete_run;
	end

	initial begin
		#100000;
		err_total++;
		complete_run;
	end
endmodule
